// ### common/sri_consts.svh
// Offsets, field positions, reset values and timing counts of the interlock
//
// Contract
// - Stop press with stop enabled, or while tripped, withdraws run.
// - Unlatched: block holds until run bits zero, disable, timeout, UV.
// - Latching: zero test uses latched bits; not-stop low also releases.
// - Forward and reverse both held 60 ms releases the block.
// - Software or hardware drive disable releases the block.
// - Undervoltage state releases the block.
// - Latching: timeout release still waits for direction latches clear.
// - Run held plus stop resets trip without stopping only in keypad mode.
// - Fwd/rev key only in keypad mode with its enable; enable resets 0.
// - Drive enable setting zero disables drive; one permits running.
// - Stop press never starts the drive; trip reset does not start it.
// - In keypad mode the stop key is always enabled.
`ifndef SRI_CONSTS_SVH
`define SRI_CONSTS_SVH

// ==========================================================
// Register offsets
`define SRI_ADDR_CTRL 8'h00
`define SRI_ADDR_STATUS 8'h04

// ==========================================================
// Control fields
`define SRI_CTRL_STOP_EN 0
`define SRI_CTRL_LATCH_EN 1
`define SRI_CTRL_FR_EN 2
`define SRI_CTRL_DRV_EN 3
`define SRI_CTRL_KEYPAD 4
`define SRI_CTRL_WIDTH 5
`define SRI_CTRL_RESET 5'h08

// ==========================================================
// Status fields
`define SRI_ST_BLOCKED 0
`define SRI_ST_LATCH_WAIT 1
`define SRI_ST_RUN 2
`define SRI_ST_DRIVE_ON 3
`define SRI_ST_DIR_REV 4
`define SRI_ST_FWD_LATCH 5
`define SRI_ST_REV_LATCH 6
`define SRI_ST_BOTH_DONE 7
`define SRI_ST_WIDTH 8

// ==========================================================
// Timing
`define SRI_CLK_HZ 40000000
`define SRI_BOTH_DIR_MS 60
`define SRI_BOTH_DIR_CYCLES (`SRI_BOTH_DIR_MS * (`SRI_CLK_HZ / 1000))
`define SRI_TIMER_WIDTH 22

`endif

// ### common/sri_pkg.sv
// Types shared by the interlock modules
package sri_pkg;
  typedef enum logic [1:0] {
    SRI_FREE,
    SRI_BLOCKED,
    SRI_LATCH_WAIT
  } sri_lock_t;
  typedef logic [7:0] sri_addr_t;
  typedef logic [31:0] sri_word_t;
endpackage

// ### sim/sri_keypad_model.sv
// Operator keypad and run command source for the interlock bench
`timescale 1ns/1ps
module sri_keypad_model (
  input wire logic clock,
  input wire logic [9:0] req,
  output logic [9:0] pins = 10'h000
);
  // ==========================================================
  // Keys and run bits change one edge after the request
  always @(posedge clock) begin
    pins <= req;
  end
endmodule

// ### sim/testbench.sv
// Self-checking bench of the stop-key run interlock
`timescale 1ns/1ps
module testbench;
  import sri_pkg::*;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  sri_addr_t adr = 8'h00;
  sri_word_t wdat = 32'h0;
  sri_word_t rdat;
  sri_word_t dout;
  logic ack;
  logic [9:0] req = 10'h140;
  logic [9:0] pin;
  logic rp, de, tr, dr;
  int miscompares = 0;
  int cmp_count = 0;
  int trips = 0;
  logic [16:0] rows [5] = '{{5'h08, 10'h148, 2'h3}, {5'h00, 10'h148, 2'h0},
    {5'h08, 10'h048, 2'h0}, {5'h18, 10'h168, 2'h3}, {5'h08, 10'h140, 2'h2}};

  sri_keypad_model i_sri_keypad_model (.clock(CLOCK), .req(req), .pins(pin));
  sri_interlock #(.BOTH_DIR_CYCLES(20)) i_sri_interlock (
    .CLOCK(CLOCK), .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(dout), .WB_ACK_O(ack), .STOP_KEY(pin[0]), .RUN_KEY(pin[1]),
    .FWD_REV_KEY(pin[2]), .RUN_FWD(pin[3]), .RUN_REV(pin[4]),
    .RUN_SEQ(pin[5]), .NOT_STOP(pin[6]), .TRIPPED(pin[7]),
    .HW_ENABLE(pin[8]), .UNDERVOLTAGE(pin[9]), .RUN_PERMIT(rp),
    .DRIVE_ENABLE(de), .TRIP_RESET(tr), .DIR_REV(dr));

  always #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (tr) trips <= trips + 1;

  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d compares %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wb(input logic w, input sri_addr_t a, input sri_word_t d);
    int n;
    n = 0;
    @(posedge CLOCK);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dout;
    cyc <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      end_of_test;
    end
  endtask
  task pins(input logic [9:0] v);
    @(posedge CLOCK);
    req <= v;
    repeat (5) @(posedge CLOCK);
    #1;
  endtask
  task stop(input logic [9:0] v);
    pins(v | 10'h001);
    pins(v);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge CLOCK);
    RSTN <= 1'b1;
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h8);
    wb(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h0);
    foreach (rows[i]) begin
      wb(1'b1, 8'h00, {27'h0, rows[i][16:12]});
      pins(rows[i][11:2]);
      chk({de, rp}, rows[i][1:0]);
    end
    wb(1'b1, 8'h00, 32'h9);
    pins(10'h148);
    stop(10'h148);
    chk(rp, 1'h0);
    pins(10'h140);
    pins(10'h148);
    chk(rp, 1'h1);
    wb(1'b1, 8'h00, 32'h8);
    stop(10'h148);
    chk(rp, 1'h1);
    wb(1'b1, 8'h00, 32'h18);
    stop(10'h148);
    chk(rp, 1'h0);
    pins(10'h048);
    pins(10'h148);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h0);
    stop(10'h148);
    wb(1'b1, 8'h00, 32'h10);
    wb(1'b1, 8'h00, 32'h18);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h0);
    stop(10'h148);
    pins(10'h348);
    pins(10'h148);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h0);
    stop(10'h148);
    pins(10'h158);
    repeat (10) @(posedge CLOCK);
    pins(10'h148);
    pins(10'h158);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h1);
    repeat (20) @(posedge CLOCK);
    wb(1'b0, 8'h04, 32'h0);
    chk({rdat[7], rdat[0]}, 2'h2);
    pins(10'h140);
    wb(1'b1, 8'h00, 32'h8);
    pins(10'h1c8);
    stop(10'h1c8);
    chk(trips, 32'h1);
    chk(rp, 1'h0);
    pins(10'h148);
    chk(rp, 1'h0);
    pins(10'h140);
    wb(1'b1, 8'h00, 32'h18);
    pins(10'h1ca);
    stop(10'h1ca);
    chk(trips, 32'h2);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h0);
    wb(1'b1, 8'h00, 32'h9);
    stop(10'h1ca);
    chk(trips, 32'h3);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h1);
    pins(10'h140);
    wb(1'b1, 8'h00, 32'h18);
    pins(10'h144);
    pins(10'h140);
    chk(dr, 1'h0);
    wb(1'b1, 8'h00, 32'h1c);
    pins(10'h144);
    pins(10'h140);
    chk(dr, 1'h1);
    wb(1'b1, 8'h00, 32'hc);
    pins(10'h144);
    pins(10'h140);
    chk(dr, 1'h1);
    wb(1'b1, 8'h00, 32'hb);
    pins(10'h148);
    pins(10'h140);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[5], 1'h1);
    stop(10'h140);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h1);
    pins(10'h100);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat[0], 1'h0);
    pins(10'h148);
    pins(10'h140);
    stop(10'h140);
    pins(10'h158);
    repeat (25) @(posedge CLOCK);
    wb(1'b0, 8'h04, 32'h0);
    chk({rp, rdat[1], rdat[0]}, 3'h2);
    pins(10'h100);
    wb(1'b1, 8'h00, 32'h1f);
    @(posedge CLOCK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RSTN <= 1'b1;
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h8);
    end_of_test;
  end
endmodule

// ### src/sri_both_timer.sv
// Timer for forward and reverse held together
`timescale 1ns/1ps
`include "sri_consts.svh"
module sri_both_timer
  import sri_pkg::*;
#(
  parameter int WIDTH = `SRI_TIMER_WIDTH,
  parameter int LIMIT = `SRI_BOTH_DIR_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic count_en,
  output logic done
);
  logic [WIDTH-1:0] cnt;
  wire logic [WIDTH-1:0] limit_w = WIDTH'(LIMIT);

  // ==========================================================
  // Counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (!count_en) begin
      cnt <= '0;
    end else if (cnt != limit_w) begin
      cnt <= cnt + WIDTH'(1);
    end
  end

  assign done = count_en && (cnt == limit_w);

  // ==========================================================
  // Checks
  property p_timer_restart;
    @(posedge clock) disable iff (!rstn)
    !count_en |=> (cnt == '0) && !done;
  endproperty
  a_timer_restart: assert property (p_timer_restart)
    else $error("Timer did not restart");

  property p_timer_count;
    @(posedge clock) disable iff (!rstn)
    count_en && (cnt != limit_w) |=> cnt == $past(cnt) + WIDTH'(1);
  endproperty
  a_timer_count: assert property (p_timer_count)
    else $error("Timer did not count");
endmodule

// ### src/sri_interlock.sv
// Stop-key run interlock with Wishbone register access
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "sri_consts.svh"
module sri_interlock
  import sri_pkg::*;
#(
  parameter int BOTH_DIR_CYCLES = `SRI_BOTH_DIR_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic STOP_KEY,
  input wire logic RUN_KEY,
  input wire logic FWD_REV_KEY,
  input wire logic RUN_FWD,
  input wire logic RUN_REV,
  input wire logic RUN_SEQ,
  input wire logic NOT_STOP,
  input wire logic TRIPPED,
  input wire logic HW_ENABLE,
  input wire logic UNDERVOLTAGE,
  output logic RUN_PERMIT,
  output logic DRIVE_ENABLE,
  output logic TRIP_RESET,
  output logic DIR_REV
);

  // ==========================================================
  // Pin synchronisers
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic stop_prev;
  logic frkey_prev;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {UNDERVOLTAGE, HW_ENABLE, TRIPPED, NOT_STOP, RUN_SEQ,
                   RUN_REV, RUN_FWD, FWD_REV_KEY, RUN_KEY, STOP_KEY};
      pin_sync <= pin_meta;
    end
  end

  wire logic stop_s = pin_sync[0];
  wire logic run_key_s = pin_sync[1];
  wire logic frkey_s = pin_sync[2];
  wire logic fwd_s = pin_sync[3];
  wire logic rev_s = pin_sync[4];
  wire logic seq_s = pin_sync[5];
  wire logic not_stop_s = pin_sync[6];
  wire logic trip_s = pin_sync[7];
  wire logic hw_en_s = pin_sync[8];
  wire logic uv_s = pin_sync[9];

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      stop_prev <= 1'b0;
      frkey_prev <= 1'b0;
    end else begin
      stop_prev <= stop_s;
      frkey_prev <= frkey_s;
    end
  end

  wire logic stop_edge = stop_s && !stop_prev;
  wire logic frkey_edge = frkey_s && !frkey_prev;

  // ==========================================================
  // Control register and bus decode
  logic [`SRI_CTRL_WIDTH-1:0] ctrl;
  sri_lock_t lock;
  sri_lock_t next_lock;
  logic fwd_latch;
  logic rev_latch;
  logic [`SRI_ST_WIDTH-1:0] status;

  wire logic stop_en = ctrl[`SRI_CTRL_STOP_EN];
  wire logic latch_en = ctrl[`SRI_CTRL_LATCH_EN];
  wire logic fr_en = ctrl[`SRI_CTRL_FR_EN];
  wire logic drv_setting = ctrl[`SRI_CTRL_DRV_EN];
  wire logic keypad = ctrl[`SRI_CTRL_KEYPAD];

  wire logic bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire logic hit_ctrl = (WB_ADR_I == `SRI_ADDR_CTRL);
  wire logic hit_status = (WB_ADR_I == `SRI_ADDR_STATUS);
  wire logic ctrl_wr = bus_req && WB_WE_I && hit_ctrl && WB_SEL_I[0];
  wire sri_word_t rd_word =
    hit_ctrl ? {{(32-`SRI_CTRL_WIDTH){1'b0}}, ctrl} :
    hit_status ? {{(32-`SRI_ST_WIDTH){1'b0}}, status} : 32'h0000_0000;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= `SRI_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= WB_DAT_I[`SRI_CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req ? rd_word : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Drive enable
  wire logic drive_on = drv_setting && hw_en_s;

  // ==========================================================
  // Run latches
  wire logic next_fwd_latch = latch_en && not_stop_s && (fwd_latch || fwd_s);
  wire logic next_rev_latch = latch_en && not_stop_s && (rev_latch || rev_s);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      fwd_latch <= 1'b0;
      rev_latch <= 1'b0;
    end else begin
      fwd_latch <= next_fwd_latch;
      rev_latch <= next_rev_latch;
    end
  end

  // ==========================================================
  // Both-direction timeout
  logic both_done;

  sri_both_timer #(
    .WIDTH(`SRI_TIMER_WIDTH),
    .LIMIT(BOTH_DIR_CYCLES)
  ) u_timer (
    .clock(CLOCK),
    .rstn(RSTN),
    .count_en(fwd_s && rev_s),
    .done(both_done)
  );

  // ==========================================================
  // Stop key action
  wire logic stop_live = stop_en || keypad;
  wire logic run_hold_reset = keypad && run_key_s && trip_s;
  wire logic stop_act = stop_edge && (stop_live || trip_s)
                        && !run_hold_reset;
  wire logic next_trip_reset = stop_edge && trip_s;

  // ==========================================================
  // Release conditions
  wire logic runs_zero = !(fwd_s || rev_s || seq_s);
  wire logic latched_zero = !(fwd_latch || rev_latch || seq_s);
  wire logic mode_release = latch_en ?
    (latched_zero || !not_stop_s) : runs_zero;
  wire logic release_any = mode_release || !drive_on || both_done
                           || uv_s;

  // ==========================================================
  // Interlock state
  always_comb begin
    next_lock = lock;
    case (lock)
      SRI_FREE: begin
        if (stop_act) begin
          next_lock = SRI_BLOCKED;
        end
      end
      SRI_BLOCKED: begin
        if (stop_act) begin
          next_lock = SRI_BLOCKED;
        end else if (latch_en && both_done && !mode_release
                     && drive_on && !uv_s) begin
          next_lock = SRI_LATCH_WAIT;
        end else if (release_any) begin
          next_lock = SRI_FREE;
        end
      end
      SRI_LATCH_WAIT: begin
        if (stop_act) begin
          next_lock = SRI_BLOCKED;
        end else if (!(fwd_latch || rev_latch) || !latch_en) begin
          next_lock = SRI_FREE;
        end
      end
      default: begin
        next_lock = SRI_BLOCKED;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      lock <= SRI_FREE;
    end else begin
      lock <= next_lock;
    end
  end

  // ==========================================================
  // Run command and outputs
  wire logic run_cmd = latch_en ? (next_fwd_latch || next_rev_latch)
                                : (fwd_s || rev_s || seq_s);
  wire logic next_run = run_cmd && (next_lock == SRI_FREE) && drive_on
                        && !trip_s && !uv_s;
  wire logic next_dir = (keypad && fr_en && frkey_edge) ?
                        !DIR_REV : DIR_REV;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RUN_PERMIT <= 1'b0;
      DRIVE_ENABLE <= 1'b0;
      TRIP_RESET <= 1'b0;
      DIR_REV <= 1'b0;
    end else begin
      RUN_PERMIT <= next_run;
      DRIVE_ENABLE <= drive_on;
      TRIP_RESET <= next_trip_reset;
      DIR_REV <= next_dir;
    end
  end

  // ==========================================================
  // Status word
  always_comb begin
    status = '0;
    status[`SRI_ST_BLOCKED] = (lock == SRI_BLOCKED);
    status[`SRI_ST_LATCH_WAIT] = (lock == SRI_LATCH_WAIT);
    status[`SRI_ST_RUN] = RUN_PERMIT;
    status[`SRI_ST_DRIVE_ON] = DRIVE_ENABLE;
    status[`SRI_ST_DIR_REV] = DIR_REV;
    status[`SRI_ST_FWD_LATCH] = fwd_latch;
    status[`SRI_ST_REV_LATCH] = rev_latch;
    status[`SRI_ST_BOTH_DONE] = both_done;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  property p_stop_blocks;
    stop_act |=> (lock == SRI_BLOCKED) && !RUN_PERMIT;
  endproperty
  a_stop_blocks: assert property (p_stop_blocks)
    else $error("Stop did not withdraw run");

  property p_plain_release;
    !latch_en && (lock == SRI_BLOCKED) && runs_zero && !stop_act
      |=> lock == SRI_FREE;
  endproperty
  a_plain_release: assert property (p_plain_release)
    else $error("Run bits zero did not release");

  property p_latch_release;
    latch_en && (lock == SRI_BLOCKED) && !not_stop_s && !stop_act
      |=> lock == SRI_FREE;
  endproperty
  a_latch_release: assert property (p_latch_release)
    else $error("Not-stop low did not release");

  property p_latch_clear;
    !(latch_en && not_stop_s) |=> !fwd_latch && !rev_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("Run latches kept without latching or not-stop");

  property p_timeout_release;
    (lock == SRI_BLOCKED) && both_done && !stop_act
      |=> lock != SRI_BLOCKED;
  endproperty
  a_timeout_release: assert property (p_timeout_release)
    else $error("Timeout did not release");

  property p_disable_release;
    !drive_on |=> !RUN_PERMIT && (lock != SRI_BLOCKED || $past(stop_act));
  endproperty
  a_disable_release: assert property (p_disable_release)
    else $error("Disabled drive kept block or run");

  property p_uv_release;
    uv_s && (lock == SRI_BLOCKED) && !stop_act |=> lock == SRI_FREE;
  endproperty
  a_uv_release: assert property (p_uv_release)
    else $error("Undervoltage did not release");

  property p_uv_no_run;
    uv_s |=> !RUN_PERMIT;
  endproperty
  a_uv_no_run: assert property (p_uv_no_run)
    else $error("Run permitted in undervoltage");

  property p_latch_wait;
    (lock == SRI_LATCH_WAIT) && (fwd_latch || rev_latch) && latch_en
      |=> !RUN_PERMIT;
  endproperty
  a_latch_wait: assert property (p_latch_wait)
    else $error("Restart before latches cleared");

  property p_run_hold;
    stop_edge && keypad && run_key_s && trip_s
      |=> TRIP_RESET
          && (lock != SRI_BLOCKED || $past(lock) == SRI_BLOCKED);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("Run-hold trip reset misbehaved");

  property p_dir_key;
    DIR_REV != $past(DIR_REV) |-> $past(keypad && fr_en && frkey_edge);
  endproperty
  a_dir_key: assert property (p_dir_key)
    else $error("Direction changed without enabled key");

  property p_drive_setting;
    !drv_setting |=> !DRIVE_ENABLE && !RUN_PERMIT;
  endproperty
  a_drive_setting: assert property (p_drive_setting)
    else $error("Drive enabled with setting zero");

  property p_stop_no_start;
    stop_edge && !RUN_PERMIT |=> !RUN_PERMIT;
  endproperty
  a_stop_no_start: assert property (p_stop_no_start)
    else $error("Stop press started the drive");

  property p_trip_no_run;
    trip_s |=> !RUN_PERMIT;
  endproperty
  a_trip_no_run: assert property (p_trip_no_run)
    else $error("Run permitted while tripped");

  property p_keypad_stop;
    stop_edge && keypad && !trip_s |=> lock == SRI_BLOCKED;
  endproperty
  a_keypad_stop: assert property (p_keypad_stop)
    else $error("Keypad stop not honoured");

  c_stop_then_release: cover property (
    stop_act ##1 (lock == SRI_BLOCKED) [*2] ##1 (lock == SRI_FREE));
  c_timeout_wait: cover property (
    (lock == SRI_BLOCKED) ##1 (lock == SRI_LATCH_WAIT));
  c_trip_reset: cover property (TRIP_RESET);
  c_dir_toggle: cover property (DIR_REV != $past(DIR_REV));
endmodule
